// >>> hw/rpes_sequencer.sv
// Purpose: regulator enable, section resets, power-on reset, strap decode
// Assumes: i_rst_n models supplies crossing the power-on threshold
// Notes:   undriven enables must be resolved high by the bench pull-ups
// How it works
// - wlan enable high turns regulators on and frees the wlan section.
// - wlan enable low holds the wlan section in reset regardless.
// - regulator enable is the or of both enables, off when both low.
// - secondary enable low with wlan high keeps the secondary in reset.
// - power-on reset releases the device within 110 ms of supply up.
// - host interface is picked by straps tied before power-up.
// - straps 000 usb, 101 sdio 1.8 V with uart, 100 sdio 3.3 V with uart.
// - each enable defaults high when left undriven.
`timescale 1ns/1ps
`include "rpes_params.svh"
module rpes_sequencer
  import rpes_pkg::*;
#(
  parameter logic [`RPES_CNT_W-1:0] POR_CYC       = `RPES_POR_CYC,
  parameter logic [`RPES_CNT_W-1:0] DISCHARGE_CYC = `RPES_DISCHARGE_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_wlan_power_enable,
  input  wire logic       i_secondary_radio_power_enable,
  input  wire logic [2:0] i_host_strap,
  input  wire logic       i_host_cmd_valid,
  output logic            o_regulator_enable,
  output logic            o_por_active,
  output logic            o_wlan_reset_n,
  output logic            o_secondary_reset_n,
  output rpes_host_cfg_t  o_host_cfg,
  output logic            o_host_cmd_accept,
  output logic            o_discharging
);
  localparam int unsigned NSEC       = 2;
  localparam int unsigned SEC_WLAN   = 1;
  localparam int unsigned SEC_RADIO2 = 0;

  // power-on reset group
  rpes_state_t            state_r;
  rpes_state_t            state_nxt;
  logic [`RPES_CNT_W-1:0] por_cnt_r;
  logic [`RPES_CNT_W-1:0] por_cnt_nxt;
  logic                   por_done;
  logic                   run;

  // host configuration group
  rpes_host_cfg_t         cfg_r;
  rpes_host_cfg_t         cfg_nxt;
  rpes_host_cfg_t         cfg_dec;
  logic                   cfg_load;

  // discharge window group
  logic [`RPES_CNT_W-1:0] dis_cnt_r;
  logic [`RPES_CNT_W-1:0] dis_cnt_nxt;
  logic                   dis_load;

  // regulator group
  logic                   any_en;
  logic                   reg_en_r;
  logic                   reg_en_nxt;

  // section group, one bit per radio section
  logic [NSEC-1:0]        sec_en;
  logic [NSEC-1:0]        sec_rst_n_r;
  logic [NSEC-1:0]        sec_rst_n_nxt;

  assign any_en = i_wlan_power_enable | i_secondary_radio_power_enable;

  // undriven high level is the pad pull-up's job, not modelled here
  assign sec_en[SEC_WLAN]   = i_wlan_power_enable;
  assign sec_en[SEC_RADIO2] = i_secondary_radio_power_enable;

  // released at the latest allowed time, never earlier
  assign por_done = (por_cnt_r >= POR_CYC);

  always_comb begin
    state_nxt   = state_r;
    por_cnt_nxt = por_cnt_r;
    cfg_load    = 1'b0;
    case (state_r)
      RPES_ST_POR: begin
        if (por_done) begin
          state_nxt = RPES_ST_RUN;
          cfg_load  = 1'b1;
        end else begin
          por_cnt_nxt = por_cnt_r + 1'b1;
        end
      end
      RPES_ST_RUN: begin
        state_nxt = RPES_ST_RUN;
      end
      default: begin
        state_nxt   = RPES_ST_POR;
        por_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= RPES_ST_POR;
      por_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      por_cnt_r <= por_cnt_nxt;
    end
  end

  // straps are static, so no synchroniser; decoded every cycle
  always_comb begin
    cfg_dec = '0;
    case (i_host_strap)
      `RPES_STRAP_USB: begin
        cfg_dec.wlan_usb   = 1'b1;
        cfg_dec.radio2_usb = 1'b1;
      end
      `RPES_STRAP_SDIO_1V8: begin
        cfg_dec.wlan_sdio   = 1'b1;
        cfg_dec.sdio_1v8    = 1'b1;
        cfg_dec.radio2_uart = 1'b1;
      end
      `RPES_STRAP_SDIO_3V3: begin
        cfg_dec.wlan_sdio           = 1'b1;
        cfg_dec.sdio_low_speed_only = 1'b1;
        cfg_dec.radio2_uart         = 1'b1;
      end
      default: begin
        cfg_dec.strap_invalid = 1'b1;
      end
    endcase
  end

  // captured once at release, so a strap moved later changes nothing
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_load) begin
      cfg_nxt = cfg_dec;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // only reports a host violation window; it never blocks the enables
  assign dis_load = ~any_en & reg_en_r;

  always_comb begin
    dis_cnt_nxt = dis_cnt_r;
    if (any_en) begin
      dis_cnt_nxt = '0;
    end else if (dis_load) begin
      dis_cnt_nxt = DISCHARGE_CYC;
    end else if (dis_cnt_r != '0) begin
      dis_cnt_nxt = dis_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dis_cnt_r <= '0;
    end else begin
      dis_cnt_r <= dis_cnt_nxt;
    end
  end

  always_comb begin
    reg_en_nxt = any_en;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_en_r <= 1'b0;
    end else begin
      reg_en_r <= reg_en_nxt;
    end
  end

  // each section follows its own enable, one cycle late
  generate
    for (genvar g = 0; g < NSEC; g++) begin : g_sec
      always_comb begin
        sec_rst_n_nxt[g] = sec_en[g];
      end

      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sec_rst_n_r[g] <= 1'b0;
        end else begin
          sec_rst_n_r[g] <= sec_rst_n_nxt[g];
        end
      end
    end
  endgenerate

  assign run                 = (state_r == RPES_ST_RUN);
  assign o_por_active        = ~run;
  assign o_regulator_enable  = reg_en_r;

  // sections stay in reset while power-on reset runs
  assign o_wlan_reset_n      = sec_rst_n_r[SEC_WLAN] & run;
  assign o_secondary_reset_n = sec_rst_n_r[SEC_RADIO2] & run;
  assign o_host_cfg          = cfg_r;

  // host must itself hold off; here early commands are only dropped
  assign o_host_cmd_accept   = i_host_cmd_valid & o_wlan_reset_n;
  assign o_discharging       = (dis_cnt_r != '0);
endmodule

// >>> hw/rpes_params.svh
// Purpose: constants of the radio power enable sequencer
// Assumes: 40 MHz system clock
// Notes:   long counts are defaults for module parameters
`ifndef RPES_PARAMS_SVH
`define RPES_PARAMS_SVH
`define RPES_CLK_MHZ         40
`define RPES_POR_MAX_MS      110
`define RPES_HOST_WAIT_MS    150
`define RPES_DISCHARGE_MS    10
`define RPES_POR_CYC         ((`RPES_POR_MAX_MS * 1000 * `RPES_CLK_MHZ) - 1)
`define RPES_DISCHARGE_CYC   (`RPES_DISCHARGE_MS * 1000 * `RPES_CLK_MHZ)
`define RPES_STRAP_USB       3'h0
`define RPES_STRAP_SDIO_1V8  3'h5
`define RPES_STRAP_SDIO_3V3  3'h4
`define RPES_CNT_W           32
`endif

// >>> hw/rpes_pkg.sv
// Purpose: types of the radio power enable sequencer
// Assumes: nothing
// Notes:   none
package rpes_pkg;
  typedef enum logic [1:0] {
    RPES_ST_POR  = 2'b00,
    RPES_ST_RUN  = 2'b01
  } rpes_state_t;
  typedef struct packed {
    logic       wlan_usb;
    logic       wlan_sdio;
    logic       sdio_1v8;
    logic       sdio_low_speed_only;
    logic       radio2_usb;
    logic       radio2_uart;
    logic       strap_invalid;
  } rpes_host_cfg_t;
endpackage

// >>> dv/rpes_host_model.sv
// Purpose: host side of the enable pins
// Assumes: a pin is released by clearing its drive bit
// Notes: released pins settle high on the pull-ups
`timescale 1ns/1ps
module rpes_host_model (
  input  wire logic [1:0] i_drive,
  input  wire logic [1:0] i_level,
  output logic            o_wlan,
  output logic            o_secondary
);
  assign o_wlan = !i_drive[1] || i_level[1];
  assign o_secondary = !i_drive[0] || i_level[0];
endmodule

// >>> dv/rpes_sequencer_properties.sv
// Purpose: port assertions of the sequencer
// Assumes: straps change only in reset
// Notes: bound from the bench
`timescale 1ns/1ps
module rpes_sequencer_properties
  import rpes_pkg::*;
#(parameter logic [31:0] POR_CYC = 32'h14, DISCHARGE_CYC = 32'ha) (
  input wire logic i_clk_sys, i_rst_n, i_wlan_power_enable,
  input wire logic i_secondary_radio_power_enable, i_host_cmd_valid,
  input wire logic [2:0] i_host_strap,
  input wire logic o_regulator_enable, o_por_active, o_wlan_reset_n,
  input wire logic o_secondary_reset_n, o_host_cmd_accept, o_discharging,
  input wire rpes_host_cfg_t o_host_cfg
);
  logic [31:0] cnt_r, cnt_nxt;
  logic [6:0] cfg_exp;
  wire logic en_any = i_wlan_power_enable | i_secondary_radio_power_enable;
  assign cfg_exp = i_host_strap == 3'h0 ? 7'h44 : i_host_strap == 3'h5 ?
    7'h32 : i_host_strap == 3'h4 ? 7'h2a : 7'h01;
  // saturates so a long run never wraps back into the window
  always_comb cnt_nxt = cnt_r + {31'h0, cnt_r <= POR_CYC};
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  por_len_a: assert property (o_por_active == (cnt_r <= POR_CYC))
    else $error("por length");
  reg_or_a: assert property ($past(i_rst_n) |->
    o_regulator_enable == $past(en_any)) else $error("regulator");
  wlan_rst_a: assert property ($past(i_rst_n) |->
    o_wlan_reset_n == ($past(i_wlan_power_enable) && !o_por_active))
    else $error("wlan reset");
  sec_rst_a: assert property ($past(i_rst_n) |-> o_secondary_reset_n ==
    ($past(i_secondary_radio_power_enable) && !o_por_active))
    else $error("secondary reset");
  cmd_gate_a: assert property (o_host_cmd_accept ==
    (i_host_cmd_valid && o_wlan_reset_n && !o_por_active)) else $error("accept");
  cfg_dec_a: assert property (!o_por_active |-> o_host_cfg == cfg_exp)
    else $error("strap decode");
  cfg_hold_a: assert property (!o_por_active && !$past(o_por_active) |->
    $stable(o_host_cfg)) else $error("cfg moved");
  dis_run_a: assert property ($fell(o_regulator_enable) |=>
    o_discharging [*8]) else $error("discharge window");
endmodule

// >>> dv/tb.sv
// Purpose: self-checking bench of the sequencer
// Assumes: shortened count parameters
// Notes: cmd valid held high to probe refusal in por
`timescale 1ns/1ps
module tb;
  import rpes_pkg::*;
  localparam logic [31:0] POR_CYC = 32'h14, DISCHARGE_CYC = 32'ha;
  logic i_clk_sys = 0, i_rst_n = 0, i_host_cmd_valid = 0;
  logic [1:0] drv = '0, lvl = '0;
  logic [2:0] i_host_strap = '0;
  logic i_wlan_power_enable, i_secondary_radio_power_enable, o_discharging;
  logic o_regulator_enable, o_por_active, o_wlan_reset_n, o_secondary_reset_n;
  logic o_host_cmd_accept;
  rpes_host_cfg_t o_host_cfg;
  int miscompares = 0, compares = 0;
  always #12.5 i_clk_sys = !i_clk_sys;
  rpes_host_model rpes_host_model_inst (.i_drive(drv), .i_level(lvl),
    .o_wlan(i_wlan_power_enable), .o_secondary(i_secondary_radio_power_enable));
  rpes_sequencer #(.POR_CYC(POR_CYC), .DISCHARGE_CYC(DISCHARGE_CYC))
    rpes_sequencer_inst (
      .i_clk_sys                      (i_clk_sys),
      .i_rst_n                        (i_rst_n),
      .i_wlan_power_enable            (i_wlan_power_enable),
      .i_secondary_radio_power_enable (i_secondary_radio_power_enable),
      .i_host_strap                   (i_host_strap),
      .i_host_cmd_valid               (i_host_cmd_valid),
      .o_regulator_enable             (o_regulator_enable),
      .o_por_active                   (o_por_active),
      .o_wlan_reset_n                 (o_wlan_reset_n),
      .o_secondary_reset_n            (o_secondary_reset_n),
      .o_host_cfg                     (o_host_cfg),
      .o_host_cmd_accept              (o_host_cmd_accept),
      .o_discharging                  (o_discharging));
  task automatic chk(input logic [6:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic power_up(input logic [2:0] s, input logic [6:0] e);
    int n = 0;
    @(posedge i_clk_sys);
    i_rst_n <= 1'h0;
    i_host_strap <= s;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'h1;
    while (o_por_active === 1'h1 && n < 100) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk(7'(n), 7'(POR_CYC + 2));
    if (n == 100) conclude;
    chk(o_host_cfg, e);
    chk(7'(o_host_cmd_accept), 7'h1);
  endtask
  task automatic enables;
    for (int k = 3; k >= -1; k--) begin
      @(posedge i_clk_sys);
      drv <= k < 0 ? 2'h0 : 2'h3;
      lvl <= k[1:0];
      @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk(7'({o_regulator_enable, o_wlan_reset_n, o_secondary_reset_n,
        o_host_cmd_accept}), 7'({k[1] | k[0], k[1], k[0], k[1]}));
      if (k == 0) begin
        @(negedge i_clk_sys);
        chk(7'(o_discharging), 7'h1);
        repeat (DISCHARGE_CYC - 2) @(negedge i_clk_sys);
        chk(7'(o_discharging), 7'h1);
        @(negedge i_clk_sys);
        chk(7'(o_discharging), 7'h0);
      end
    end
  endtask
  initial begin
    logic [2:0] st[4] = '{3'h0, 3'h5, 3'h4, 3'h7};
    logic [6:0] cf[4] = '{7'h44, 7'h32, 7'h2a, 7'h01};
    i_host_cmd_valid <= 1'h1;
    foreach (st[i]) power_up(st[i], cf[i]);
    enables;
    conclude;
  end
endmodule
bind rpes_sequencer rpes_sequencer_properties #(.POR_CYC(POR_CYC),
  .DISCHARGE_CYC(DISCHARGE_CYC)) rpes_sequencer_properties_inst (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_wlan_power_enable(i_wlan_power_enable),
  .i_secondary_radio_power_enable(i_secondary_radio_power_enable),
  .i_host_cmd_valid(i_host_cmd_valid), .i_host_strap(i_host_strap),
  .o_regulator_enable(o_regulator_enable), .o_por_active(o_por_active),
  .o_wlan_reset_n(o_wlan_reset_n), .o_secondary_reset_n(o_secondary_reset_n),
  .o_host_cmd_accept(o_host_cmd_accept), .o_discharging(o_discharging),
  .o_host_cfg(o_host_cfg));
